// ===== hw/eeprom_readback_alarm_limits.sv
// configuration loader top: avalon register slave, eeprom read-back, fault mux
// assumes i_clock 50 MHz, synchronous reset, eeprom on a four-wire link
//
// Behaviour
// - underscale code maps 450 mV down by 25 mV per step to 275 mV
// - automatic controller reads configuration registers from eeprom
// - read-back active after reset until a fetched image sets the disable bit
// - continuous mode starts the next read right after completion
// - disable bit in register 4 gives one read then stop
// - per-fault bit: one drives overscale, zero underscale
// - bits 7..4: neg hi/pos lo, neg lo/pos hi, both lo, both hi
// - bits 3..0: pos lo, pos hi, neg lo, neg hi with other in range
// - up to five input channel configurations selectable
// - sixteen overscale and eight underscale levels in register 5
// - underscale limit wins over zero setting when higher
`timescale 1ns/1ps
module eeprom_readback_alarm_limits (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// avalon-mm slave
	input wire logic [5:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// eeprom link
	output logic o_ee_sclk,
	output logic o_ee_cs_n,
	output logic o_ee_mosi,
	input wire logic i_ee_miso,
	// sense inputs
	input wire logic [1:0] i_negative_sense_input,
	input wire logic [1:0] i_positive_sense_input,
	input wire logic [9:0] i_zero_mv,
	// outputs
	output logic o_overscale,
	output logic o_underscale,
	output logic [3:0] o_os_code,
	output logic [9:0] o_low_limit_mv,
	output logic [2:0] o_channel,
	output logic o_loading
);
	// ********************************************************
	// synchronisers
	// ********************************************************
	logic miso_s1_ff, miso_s2_ff;
	logic [3:0] sense_s1_ff, sense_s2_ff;
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			miso_s1_ff <= 1'b0; miso_s2_ff <= 1'b0;
			sense_s1_ff <= 4'h0; sense_s2_ff <= 4'h0;
		end else begin
			miso_s1_ff <= i_ee_miso; miso_s2_ff <= miso_s1_ff;
			sense_s1_ff <= {i_negative_sense_input, i_positive_sense_input};
			sense_s2_ff <= sense_s1_ff;
		end
	end
	// ********************************************************
	// register file
	// ********************************************************
	logic [7:0] regs_ff [cfg_loader_pkg::NUM_REGS];
	logic ack_ff;
	logic [31:0] rdata_ff;
	ee_link_if link ();
	wire access = i_read || i_write;
	wire [3:0] idx = i_address[5:2];
	// a write lands only at the edge that completes the transfer
	wire wr_go = i_write && ack_ff && i_byteenable[0];
	wire rd_done = link.done;
	wire readback_disable_bit = regs_ff[cfg_loader_pkg::IDX_CTRL2][cfg_loader_pkg::RBD_BIT];
	typedef logic [7:0] load_status_t;
	load_status_t status;
	assign status = {6'h00, readback_disable_bit, link.busy};
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			for (int i = 0; i < cfg_loader_pkg::NUM_REGS; i++)
				regs_ff[i] <= cfg_loader_pkg::RST_REG;
		end else if (rd_done) begin
			for (int i = 0; i < cfg_loader_pkg::NUM_REGS; i++)
				regs_ff[i] <= link.image[(cfg_loader_pkg::NUM_REGS-1-i)*8 +: 8];
		end else if (wr_go && idx != cfg_loader_pkg::IDX_STATUS) begin
			regs_ff[idx] <= i_writedata[7:0];
		end
	end
	// one wait cycle; answer on the second edge
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			ack_ff <= 1'b0; rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= access && !ack_ff;
			rdata_ff <= {24'h00_0000, (idx == cfg_loader_pkg::IDX_STATUS) ? status : regs_ff[idx]};
		end
	end
	assign o_waitrequest = access && !ack_ff;
	assign o_readdata = rdata_ff;
	// ********************************************************
	// read-back controller
	// ********************************************************
	cfg_loader_pkg::load_state_e state_ff, nxt_state;
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			cfg_loader_pkg::LD_IDLE: nxt_state = cfg_loader_pkg::LD_SHIFT;
			cfg_loader_pkg::LD_SHIFT: if (link.done) nxt_state = cfg_loader_pkg::LD_DONE;
			// fetched image decides whether another pass follows
			cfg_loader_pkg::LD_DONE: nxt_state = readback_disable_bit ?
				cfg_loader_pkg::LD_STOP : cfg_loader_pkg::LD_SHIFT;
			cfg_loader_pkg::LD_STOP: if (!readback_disable_bit) nxt_state = cfg_loader_pkg::LD_SHIFT;
			default: nxt_state = cfg_loader_pkg::LD_IDLE;
		endcase
	end
	always_ff @(posedge i_clock) begin
		if (i_rst)
			state_ff <= cfg_loader_pkg::LD_IDLE;
		else
			state_ff <= nxt_state;
	end
	assign link.start = (nxt_state == cfg_loader_pkg::LD_SHIFT) && !link.busy;
	ee_shift_engine u_engine (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.link(link),
		.i_miso_sync(miso_s2_ff),
		.o_sclk(o_ee_sclk),
		.o_cs_n(o_ee_cs_n),
		.o_mosi(o_ee_mosi)
	);
	// ********************************************************
	// fault selector and limits
	// ********************************************************
	wire [7:0] scale_reg = regs_ff[cfg_loader_pkg::IDX_SCALE];
	wire [9:0] us_mv;
	logic [9:0] low_ff;
	logic over_ff, under_ff;
	logic [3:0] os_ff;
	logic [2:0] chan_ff;
	wire ov_w, un_w;
	fault_selector u_sel (
		.i_neg_state(sense_s2_ff[3:2]),
		.i_pos_state(sense_s2_ff[1:0]),
		.i_fault_dir(regs_ff[cfg_loader_pkg::IDX_FAULT_DIR]),
		.i_us_code(scale_reg[cfg_loader_pkg::US_LSB +: 3]),
		.o_fault(),
		.o_overscale(ov_w),
		.o_underscale(un_w),
		.o_us_mv(us_mv)
	);
	wire [2:0] chan_raw = regs_ff[cfg_loader_pkg::IDX_CHAN_SEL][2:0];
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			over_ff <= 1'b0; under_ff <= 1'b0; os_ff <= 4'h0;
			low_ff <= 10'h000; chan_ff <= 3'h0;
		end else begin
			over_ff <= ov_w; under_ff <= un_w;
			os_ff <= scale_reg[cfg_loader_pkg::OS_LSB +: 4];
			low_ff <= (us_mv > i_zero_mv) ? us_mv : i_zero_mv;
			chan_ff <= (chan_raw > cfg_loader_pkg::CHAN_MAX) ? cfg_loader_pkg::CHAN_MAX : chan_raw;
		end
	end
	assign o_overscale = over_ff;
	assign o_underscale = under_ff;
	assign o_os_code = os_ff;
	assign o_low_limit_mv = low_ff;
	assign o_channel = chan_ff;
	assign o_loading = link.busy;
	// ********************************************************
	// checks
	// ********************************************************
	chk_stop_after_one: assert property (@(posedge i_clock) disable iff (i_rst)
		(state_ff == cfg_loader_pkg::LD_DONE && readback_disable_bit) |=> !link.busy [*8])
		else $error("read-back continued with disable set");
	chk_continuous_restart: assert property (@(posedge i_clock) disable iff (i_rst)
		(state_ff == cfg_loader_pkg::LD_DONE && !readback_disable_bit) |=> link.busy)
		else $error("no immediate restart");
	chk_active_after_reset: assert property (@(posedge i_clock)
		$fell(i_rst) |-> ##[1:3] link.busy)
		else $error("read-back not active after reset");
	chk_image_copied: assert property (@(posedge i_clock) disable iff (i_rst)
		link.done |=> regs_ff[cfg_loader_pkg::IDX_FAULT_DIR] == $past(link.image[71:64]))
		else $error("image not copied");
	chk_dir_overscale: assert property (@(posedge i_clock) disable iff (i_rst)
		(ov_w && !un_w) |=> o_overscale && !o_underscale)
		else $error("overscale not driven");
	chk_fault_both_low: assert property (@(posedge i_clock) disable iff (i_rst)
		(sense_s2_ff == 4'h5) |-> ov_w == regs_ff[cfg_loader_pkg::IDX_FAULT_DIR][5])
		else $error("both-low fault misrouted");
	chk_fault_pos_low: assert property (@(posedge i_clock) disable iff (i_rst)
		(sense_s2_ff == 4'h1) |-> ov_w == regs_ff[cfg_loader_pkg::IDX_FAULT_DIR][3])
		else $error("positive-low fault misrouted");
	chk_underscale_map: assert property (@(posedge i_clock) disable iff (i_rst)
		us_mv == 10'h1C2 - 10'(scale_reg[6:4] * 5'h19))
		else $error("underscale limit wrong");
	chk_low_floor: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_rst |=> (o_low_limit_mv >= $past(us_mv)))
		else $error("underscale limit not enforced");
	chk_os_code_follows: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_rst |=> (o_os_code == $past(scale_reg[cfg_loader_pkg::OS_LSB +: 4])))
		else $error("overscale code not applied");
	chk_write_lands: assert property (@(posedge i_clock) disable iff (i_rst)
		(wr_go && !rd_done && idx == cfg_loader_pkg::IDX_FAULT_DIR)
		|=> regs_ff[cfg_loader_pkg::IDX_FAULT_DIR] == $past(i_writedata[7:0]))
		else $error("alarm direction write lost");
	chk_channel_range: assert property (@(posedge i_clock) disable iff (i_rst)
		o_channel <= 3'h4)
		else $error("channel out of range");
endmodule : eeprom_readback_alarm_limits

// ===== hw/cfg_loader_pkg.sv
// package for the configuration loader: register map, fields, limits, timing
// assumes a 50 MHz system clock and a four-wire serial eeprom link
package cfg_loader_pkg;
	// ********************************************************
	// register map (word index, byte address = index * 4)
	// ********************************************************
	localparam int NUM_REGS = 16;
	localparam logic [3:0] IDX_CTRL2 = 4'h4;
	localparam logic [3:0] IDX_SCALE = 4'h5;
	localparam logic [3:0] IDX_FAULT_DIR = 4'h7;
	localparam logic [3:0] IDX_CHAN_SEL = 4'h8;
	localparam logic [3:0] IDX_STATUS = 4'hF;
	localparam logic [7:0] RST_REG = 8'h00;
	// ********************************************************
	// fields
	// ********************************************************
	localparam int RBD_BIT = 0;
	localparam int US_LSB = 4;
	localparam int OS_LSB = 0;
	localparam int NUM_CHANNELS = 5;
	localparam logic [2:0] CHAN_MAX = 3'h4;
	// ********************************************************
	// underscale limit in mV
	// ********************************************************
	localparam logic [9:0] US_BASE_MV = 10'h1C2;
	localparam logic [9:0] US_STEP_MV = 10'h019;
	// ********************************************************
	// link timing
	// ********************************************************
	localparam int CLK_MHZ = 50;
	localparam int SCLK_HALF_NS = 200;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] EE_READ_CMD = 8'h03;
	localparam int EE_BITS = 16 + NUM_REGS * 8;
	typedef enum {LD_IDLE, LD_SHIFT, LD_DONE, LD_STOP} load_state_e;
endpackage : cfg_loader_pkg

// ===== hw/ee_link_if.sv
// bundles the serial eeprom link between loader and shift engine
// assumes one clock domain
`timescale 1ns/1ps
interface ee_link_if;
	logic start;
	logic busy;
	logic done;
	logic [cfg_loader_pkg::NUM_REGS*8-1:0] image;
	modport ctrl (output start, input busy, input done, input image);
	modport eng (input start, output busy, output done, output image);
endinterface : ee_link_if

// ===== hw/ee_shift_engine.sv
// shifts a read command to the eeprom and collects the whole register image
// assumes the eeprom data pin is already synchronised by the caller
`timescale 1ns/1ps
module ee_shift_engine (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// link
	ee_link_if.eng link,
	input wire logic i_miso_sync,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_mosi
);
	logic [7:0] div_ff;
	logic [8:0] bit_ff;
	logic [23:0] cmd_ff;
	logic [cfg_loader_pkg::NUM_REGS*8-1:0] img_ff;
	logic busy_ff, sclk_ff, done_ff;
	wire half_tick = (div_ff == 8'(cfg_loader_pkg::SCLK_HALF_CYC - 1));
	wire last_bit = (bit_ff == 9'(cfg_loader_pkg::EE_BITS + 8 - 1));
	wire in_data = (bit_ff >= 9'(cfg_loader_pkg::EE_BITS + 8 - cfg_loader_pkg::NUM_REGS * 8));
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			div_ff <= 8'h00; bit_ff <= 9'h000; busy_ff <= 1'b0; sclk_ff <= 1'b0;
			done_ff <= 1'b0; cmd_ff <= 24'h00_0000; img_ff <= '0;
		end else begin
			done_ff <= 1'b0;
			if (!busy_ff && link.start) begin
				busy_ff <= 1'b1; bit_ff <= 9'h000; div_ff <= 8'h00;
				cmd_ff <= {cfg_loader_pkg::EE_READ_CMD, 16'h0000};
			end else if (busy_ff) begin
				div_ff <= half_tick ? 8'h00 : div_ff + 8'h01;
				if (half_tick) begin
					sclk_ff <= ~sclk_ff;
					if (!sclk_ff && in_data)
						img_ff <= {img_ff[cfg_loader_pkg::NUM_REGS*8-2:0], i_miso_sync};
					if (sclk_ff) begin
						cmd_ff <= {cmd_ff[22:0], 1'b0};
						bit_ff <= bit_ff + 9'h001;
						if (last_bit) begin
							busy_ff <= 1'b0; done_ff <= 1'b1;
						end
					end
				end
			end
		end
	end
	assign o_sclk = sclk_ff;
	assign o_cs_n = ~busy_ff;
	assign o_mosi = cmd_ff[23];
	assign link.busy = busy_ff;
	assign link.done = done_ff;
	assign link.image = img_ff;
endmodule : ee_shift_engine

// ===== hw/fault_selector.sv
// picks overscale or underscale per detected input fault; decodes the underscale limit
// assumes fault levels already synchronised
`timescale 1ns/1ps
module fault_selector (
	// inputs
	input wire logic [1:0] i_neg_state,
	input wire logic [1:0] i_pos_state,
	input wire logic [7:0] i_fault_dir,
	input wire logic [2:0] i_us_code,
	// outputs
	output logic o_fault,
	output logic o_overscale,
	output logic o_underscale,
	output logic [9:0] o_us_mv
);
	// state code: 00 in range, 01 low, 10 high
	function automatic logic [7:0] fault_onehot(input logic [1:0] n, input logic [1:0] p);
		fault_onehot = {n == 2'b10 && p == 2'b01, n == 2'b01 && p == 2'b10,
			n == 2'b01 && p == 2'b01, n == 2'b10 && p == 2'b10,
			n == 2'b00 && p == 2'b01, n == 2'b00 && p == 2'b10,
			n == 2'b01 && p == 2'b00, n == 2'b10 && p == 2'b00};
	endfunction : fault_onehot
	wire [7:0] hits = fault_onehot(i_neg_state, i_pos_state);
	assign o_fault = |hits;
	assign o_overscale = |(hits & i_fault_dir);
	assign o_underscale = o_fault && !o_overscale;
	assign o_us_mv = cfg_loader_pkg::US_BASE_MV - 10'(i_us_code * cfg_loader_pkg::US_STEP_MV);
endmodule : fault_selector

// ===== dv/ee_model.sv
// serial eeprom model: streams a 16-byte image, records the command bits
// assumes cs_n low frames each read and data is sampled on sclk rising edges
`timescale 1ns/1ps
module ee_model (
	// link
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	output logic o_miso
);
	// ********
	// storage and stream
	// ********
	logic [7:0] mem [16];
	logic [23:0] cmd_bits = 24'h00_0000;
	int nrise = 0;
	initial o_miso = 1'b0;
	always @(negedge i_cs_n) nrise = 0;
	always @(posedge i_sclk) if (!i_cs_n) begin
		if (nrise < 24) cmd_bits = {cmd_bits[22:0], i_mosi};
		nrise = nrise + 1;
	end
	// released or outside the data phase: the line shows no stale value
	always @(negedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n !== 1'b0 || nrise < 24 || nrise > 151) o_miso = ~o_miso;
		else o_miso = mem[(nrise - 24) / 8][7 - (nrise - 24) % 8];
	end
endmodule : ee_model

// ===== dv/tb_eeprom_readback_alarm_limits.sv
// testbench for the configuration loader: bus, read-back, limits, faults
// assumes the eeprom model on the link and a 50 MHz clock
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb_eeprom_readback_alarm_limits;
	// ********
	// stimulus and model
	// ********
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [5:0] addr = 6'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] be = 4'hF;
	logic [3:0] be_val = 4'hF;
	logic [1:0] neg = 2'h0;
	logic [1:0] pos = 2'h0;
	logic [9:0] zero = 10'h000;
	logic [31:0] rdata;
	logic wt, sclk, cs_n, mosi, miso, ovr, und, loading;
	logic [3:0] os;
	logic [9:0] lim;
	logic [2:0] chan;
	logic [7:0] d;
	int n_errors = 0;
	int check_count = 0;
	int seed = 96;
	int n, u;
	int exp_regs [16];
	initial forever #10 clk = ~clk;
	eeprom_readback_alarm_limits u_eeprom_readback_alarm_limits (.i_clock(clk), .i_rst(rst),
		.i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata), .i_byteenable(be),
		.o_readdata(rdata), .o_waitrequest(wt), .o_ee_sclk(sclk), .o_ee_cs_n(cs_n),
		.o_ee_mosi(mosi), .i_ee_miso(miso), .i_negative_sense_input(neg),
		.i_positive_sense_input(pos), .i_zero_mv(zero), .o_overscale(ovr), .o_underscale(und),
		.o_os_code(os), .o_low_limit_mv(lim), .o_channel(chan), .o_loading(loading));
	ee_model u_ee (.i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso));
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	// one avalon transfer held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] v,
		output logic [31:0] q);
		int k;
		@(posedge clk);
		addr <= {i, 2'b00};
		rd <= !w;
		wr <= w;
		wdata <= {24'h00_0000, v};
		be <= be_val;
		// the edge that sees waitrequest low completes the transfer and carries the data
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (wt === 1'b0) break;
		end
		if (k == 50) begin n_errors++; finish_test(); end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic wr_reg(input logic [3:0] i, input logic [7:0] v);
		logic [31:0] q;
		bus(1'b1, i, v, q);
		if (be_val[0] && i != 4'hF) exp_regs[i] = v;
	endtask : wr_reg
	task automatic rd_chk(input logic [3:0] i);
		logic [31:0] q;
		bus(1'b0, i, 8'h00, q);
		`CHK("readdata", exp_regs[i], q)
	endtask : rd_chk
	task automatic wait_idle;
		int k;
		for (k = 0; k < 5000 && loading !== 1'b0; k++) @(negedge clk);
		if (k == 5000) begin n_errors++; finish_test(); end
	endtask : wait_idle
	task automatic expect_load(input int lim_cyc);
		int k;
		for (k = 0; k < lim_cyc && loading !== 1'b1; k++) @(negedge clk);
		`CHK("loading", 1'b1, loading)
	endtask : expect_load
	initial begin
		for (int k = 0; k < 16; k++) begin
			u_ee.mem[k] = (k == 4 || k == 15) ? 8'h00 : 8'($random(seed));
			exp_regs[k] = u_ee.mem[k];
		end
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		expect_load(5);
		wait_idle();
		expect_load(3);
		`CHK("command", 24'h03_0000, u_ee.cmd_bits)
		for (int k = 0; k < 15; k++) rd_chk(4'(k));
		$display("continuous read-back test done");
		u_ee.mem[4] = 8'h01;
		exp_regs[4] = 1;
		exp_regs[15] = 2;
		wait_idle();
		repeat (4) @(negedge clk);
		wait_idle();
		for (n = 0; n < 300; n++) begin
			@(negedge clk);
			`CHK("stopped", 1'b0, loading)
		end
		rd_chk(4'hF);
		wr_reg(4'hF, 8'hFF);
		be_val = 4'hE;
		wr_reg(4'h7, 8'h5A);
		be_val = 4'hF;
		rd_chk(4'hF);
		rd_chk(4'h7);
		$display("single read test done");
		for (int i = 0; i < 16; i++) begin
			wr_reg(4'h5, {1'b0, 3'(i), 4'(i)});
			zero <= 10'(250 + $unsigned($random(seed)) % 226);
			repeat (6) @(negedge clk);
			u = 450 - 25 * (i % 8);
			u = u > zero ? u : zero;
			`CHK("os code", 4'(i), os)
			`CHK("low limit", 10'(u), lim)
		end
		rd_chk(4'h5);
		for (int v = 0; v < 8; v++) begin
			wr_reg(4'h8, 8'(v));
			repeat (4) @(negedge clk);
			`CHK("channel", 3'(v > 4 ? 4 : v), chan)
		end
		$display("limit and channel test done");
		for (int r = 0; r < 2; r++) begin
			d = r ? ~d : 8'($random(seed));
			wr_reg(4'h7, d);
			for (int b = 0; b < 8; b++) begin
				{neg, pos} <= 4'(32'h965A_1248 >> (4 * b));
				repeat (8) @(negedge clk);
				`CHK("overscale", d[b], ovr)
				`CHK("underscale", ~d[b], und)
				@(posedge clk);
			end
			{neg, pos} <= 4'h0;
			repeat (8) @(negedge clk);
			`CHK("no fault", 2'b00, {ovr, und})
		end
		$display("fault direction test done");
		wr_reg(4'h4, 8'h00);
		expect_load(6);
		wait_idle();
		for (int k = 0; k < 15; k++) exp_regs[k] = u_ee.mem[k];
		rd_chk(4'h5);
		rd_chk(4'h7);
		$display("restart test done");
		finish_test();
	end
endmodule : tb_eeprom_readback_alarm_limits
